// ### ceag_addr_gen.sv
// Effective address generator: mode decode, operand count, address forming
`timescale 1ns/10ps
module ceag_addr_gen
   import ceag_pkg::*;
(
   input wire logic mclk,
   input wire logic srst,
   input wire logic start,
   input wire logic [15:0] pc,
   input wire logic [7:0] idx_x,
   input wire logic [7:0] idx_y,
   input wire logic irq,
   input wire ceag_pkg::ceag_byte_t rd,
   output ceag_pkg::ceag_fetch_t fetch,
   output ceag_pkg::ceag_result_t result,
   output logic busy,
   output logic dev_reset,
   output logic wait_state
);
   import ceag_pkg::*;

   typedef struct packed {
      ceag_state_t st;
      logic [15:0] fa;
      logic freq;
      logic alt;
      logic ind;
      logic [7:0] opc;
      ceag_mode_t mode;
      logic lng;
      logic rmw;
      logic [1:0] need;
      logic [15:0] opnd;
      logic [15:0] ptr;
      logic [2:0] len;
      logic [15:0] ea;
      logic done;
      logic rst_req;
      logic wt;
   } ceag_reg_t;

   ceag_reg_t q, d;
   logic [3:0] row;
   logic [7:0] xsel;
   logic [15:0] nxt_pc;
   logic [15:0] rel_tgt;

   assign row = rd.data[7:4];
   assign xsel = q.alt ? idx_y : idx_x;
   // Next instruction address: pc of first byte (prefix if any) plus total length
   assign nxt_pc = pc + {13'h0000, q.len};
   // Sign extension of the displacement byte
   assign rel_tgt = nxt_pc + {{8{q.opnd[7]}}, q.opnd[7:0]};

   always_comb begin
      d = q;
      d.done = 1'b0;
      d.freq = 1'b0;
      case (q.st)
         S_OPC: begin
            if (start && !q.freq && !q.wt) begin
               d.fa = pc;
               d.freq = 1'b1;
               d.alt = 1'b0;
               d.ind = 1'b0;
               d.len = 3'h1;
               d.opnd = 16'h0000;
            end else if (rd.valid && !q.wt) begin
               d.fa = q.fa + 16'h0001;
               if (rd.data == PFX_ALT) begin
                  d.alt = 1'b1;
                  d.freq = 1'b1;
                  d.len = q.len + 3'h1;
               end else if (rd.data == PFX_IND) begin
                  d.ind = 1'b1;
                  d.freq = 1'b1;
                  d.len = q.len + 3'h1;
               end else if (rd.data == PFX_AIND) begin
                  d.alt = 1'b1;
                  d.ind = 1'b1;
                  d.freq = 1'b1;
                  d.len = q.len + 3'h1;
               end else begin
                  d.opc = rd.data;
                  d.lng = 1'b0;
                  d.rmw = 1'b0;
                  d.need = 2'h0;
                  case (row)
                     ROW_IMM: begin
                        d.mode = CEAG_IMMEDIATE;
                        d.need = 2'h1;
                     end
                     ROW_SHORT, ROW_DIRECT_RMW: begin
                        d.mode = q.ind ? CEAG_INDIRECT : CEAG_DIRECT;
                        // Short pointer form never reaches past page zero
                        d.lng = 1'b0;
                        d.rmw = (row == ROW_DIRECT_RMW);
                        d.need = 2'h1;
                     end
                     ROW_LONG: begin
                        d.mode = q.ind ? CEAG_INDIRECT : CEAG_DIRECT;
                        d.lng = 1'b1;
                        d.need = q.ind ? 2'h1 : 2'h2;
                     end
                     ROW_SIDX, ROW_IDX1_RMW: begin
                        d.mode = q.ind ? CEAG_IND_INDEXED : CEAG_INDEXED;
                        d.rmw = (row == ROW_IDX1_RMW);
                        d.need = 2'h1;
                     end
                     ROW_LIDX: begin
                        d.mode = q.ind ? CEAG_IND_INDEXED : CEAG_INDEXED;
                        d.lng = 1'b1;
                        d.need = q.ind ? 2'h1 : 2'h2;
                     end
                     ROW_NIDX, ROW_IDX0_RMW: begin
                        d.mode = CEAG_INDEXED;
                        d.rmw = (row == ROW_IDX0_RMW);
                        d.need = 2'h0;
                     end
                     ROW_REL: begin
                        d.mode = CEAG_RELATIVE;
                        d.need = 2'h1;
                     end
                     ROW_BIT: begin
                        d.mode = CEAG_BIT;
                        d.rmw = 1'b1;
                        d.need = 2'h1;
                     end
                     ROW_BTJ: begin
                        d.mode = CEAG_BIT_REL;
                        d.rmw = 1'b1;
                        d.need = 2'h2;
                     end
                     default: begin
                        d.mode = CEAG_INHERENT;
                        d.need = 2'h0;
                     end
                  endcase
                  if (rd.data == OPC_HALT) begin
                     d.rst_req = 1'b1;
                  end
                  if (rd.data == OPC_WFI) begin
                     d.wt = 1'b1;
                  end
                  if (d.need != 2'h0) begin
                     d.st = S_OPA;
                     d.freq = 1'b1;
                  end else begin
                     d.st = S_DONE;
                  end
               end
            end
            if (q.wt && irq) begin
               d.wt = 1'b0;
            end
         end
         S_OPA: begin
            if (rd.valid) begin
               d.len = q.len + 3'h1;
               d.fa = q.fa + 16'h0001;
               d.opnd = {8'h00, rd.data};
               if (q.need == 2'h2) begin
                  d.st = S_OPB;
                  d.freq = 1'b1;
               end else if (q.ind) begin
                  // Pointer always sits in page zero
                  d.fa = {ZERO8, rd.data};
                  d.st = S_PTRH;
                  d.freq = 1'b1;
               end else begin
                  d.st = S_DONE;
               end
            end
         end
         S_OPB: begin
            if (rd.valid) begin
               d.len = q.len + 3'h1;
               if (q.mode == CEAG_BIT_REL) begin
                  // Address then displacement: keep only address byte
                  d.opnd = {8'h00, q.opnd[7:0]};
                  d.ptr = {8'h00, rd.data};
               end else begin
                  d.opnd = {q.opnd[7:0], rd.data};
               end
               d.st = S_DONE;
            end
         end
         S_PTRH: begin
            if (rd.valid) begin
               d.ptr = {8'h00, rd.data};
               if (q.lng) begin
                  d.fa = q.fa + 16'h0001;
                  d.st = S_PTRL;
                  d.freq = 1'b1;
               end else begin
                  d.st = S_DONE;
               end
            end
         end
         S_PTRL: begin
            if (rd.valid) begin
               // Most significant byte came first
               d.ptr = {q.ptr[7:0], rd.data};
               d.st = S_DONE;
            end
         end
         S_DONE: begin
            d.done = 1'b1;
            d.st = S_OPC;
            case (q.mode)
               CEAG_DIRECT: begin
                  d.ea = q.lng ? q.opnd : {ZERO8, q.opnd[7:0]};
               end
               CEAG_INDIRECT: begin
                  d.ea = q.lng ? q.ptr : {ZERO8, q.ptr[7:0]};
               end
               CEAG_INDEXED: begin
                  // Short sum kept at 16 bits so it can pass FF
                  d.ea = q.opnd + {8'h00, xsel};
               end
               CEAG_IND_INDEXED: begin
                  d.ea = q.ptr + {8'h00, xsel};
               end
               CEAG_RELATIVE: begin
                  if (q.ind) begin
                     // Displacement fetched through the pointer
                     d.ea = nxt_pc + {{8{q.ptr[7]}}, q.ptr[7:0]};
                  end else begin
                     d.ea = rel_tgt;
                  end
               end
               CEAG_BIT, CEAG_BIT_REL: begin
                  d.ea = q.ind ? {ZERO8, q.ptr[7:0]} : {ZERO8, q.opnd[7:0]};
               end
               default: begin
                  d.ea = q.opnd;
               end
            endcase
         end
         default: begin
            d.st = S_OPC;
         end
      endcase
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         fetch <= '0;
         result <= '0;
         busy <= 1'b0;
         dev_reset <= 1'b0;
         wait_state <= 1'b0;
      end else begin
         fetch.req <= d.freq;
         fetch.addr <= d.fa;
         result.valid <= d.done;
         result.mode <= d.mode;
         result.long_form <= d.lng;
         result.rmw <= d.rmw;
         result.ea <= d.ea;
         result.len <= d.len;
         result.opcode <= d.opc;
         busy <= (d.st != S_OPC);
         dev_reset <= d.rst_req;
         wait_state <= d.wt;
      end
   end

   a_rmw_short: assert property (@(posedge mclk) disable iff (srst)
      (result.valid && result.rmw) |-> !result.long_form)
      else $error("rmw instruction with long form");
   a_short_page0: assert property (@(posedge mclk) disable iff (srst)
      (result.valid && !result.long_form &&
       (result.mode == CEAG_DIRECT || result.mode == CEAG_INDIRECT))
      |-> result.ea <= PAGE0_TOP)
      else $error("short form left page zero");
   a_inherent_len: assert property (@(posedge mclk) disable iff (srst)
      (result.valid && result.mode == CEAG_INHERENT)
      |-> result.len <= 3'h2)
      else $error("inherent length wrong");
   a_halt_reset: assert property (@(posedge mclk) disable iff (srst)
      (q.st == S_OPC && rd.valid && rd.data == OPC_HALT && !q.wt)
      |-> ##1 q.rst_req ##1 dev_reset)
      else $error("halt did not request reset");
   a_wait_hold: assert property (@(posedge mclk) disable iff (srst)
      (wait_state && !irq) |=> wait_state)
      else $error("wait left without interrupt");
   a_imm_len: assert property (@(posedge mclk) disable iff (srst)
      (result.valid && result.mode == CEAG_IMMEDIATE && result.opcode
       == q.opc) |-> result.len >= 3'h2)
      else $error("immediate length short");
   a_sidx_range: assert property (@(posedge mclk) disable iff (srst)
      (result.valid && result.mode == CEAG_INDEXED && !result.long_form)
      |-> result.ea <= 16'h01FE)
      else $error("short indexed out of range");
   a_fetch_pulse: assert property (@(posedge mclk) disable iff (srst)
      fetch.req |=> !fetch.req)
      else $error("fetch request stuck");

   // Long forms cost at least one extra byte over the opcode
   sequence s_long_done;
      result.valid && result.long_form && !result.rmw;
   endsequence
   a_long_len: assert property (@(posedge mclk) disable iff (srst)
      s_long_done |-> result.len >= 3'h2)
      else $error("long form too short");

   a_done_idle: assert property (@(posedge mclk) disable iff (srst)
      result.valid |-> !busy)
      else $error("busy during result");

   // Nothing is fetched while waiting, which keeps the bus quiet
   a_wait_nofetch: assert property (@(posedge mclk) disable iff (srst)
      wait_state |-> !fetch.req)
      else $error("fetch during wait state");
endmodule

// ### ceag_mem_model.sv
// Memory model answering the address unit's byte fetches
`timescale 1ns/10ps
module ceag_mem_model
   import ceag_pkg::*;
(
   input wire logic mclk,
   input wire logic [1:0] lat,
   input wire ceag_pkg::ceag_fetch_t fetch,
   output ceag_pkg::ceag_byte_t rd
);
   logic [7:0] mem [logic [15:0]];
   logic pend = 1'b0;
   logic [15:0] addr = 16'h0000;
   int cnt = 0;
   initial rd = '{valid: 1'b0, data: 8'h00};
   task automatic put(input logic [15:0] a, input logic [7:0] d);
      mem[a] = d;
   endtask
   // Data is not held once valid drops, so it toggles to expose late sampling
   always @(negedge mclk) begin
      if (pend && cnt == 0) begin
         rd.valid <= 1'b1;
         rd.data <= mem.exists(addr) ? mem[addr] : 8'h5A;
         pend = 1'b0;
      end else begin
         rd.valid <= 1'b0;
         rd.data <= ~rd.data;
         if (pend) begin
            cnt--;
         end
      end
      if (fetch.req === 1'b1) begin
         pend = 1'b1;
         addr = fetch.addr;
         cnt = lat;
      end
   end
endmodule

// ### ceag_pkg.sv
// Package: addressing modes, opcode fields and prefixes for the address unit
package ceag_pkg;
   localparam logic [7:0] PFX_ALT = 8'h90;
   localparam logic [7:0] PFX_IND = 8'h92;
   localparam logic [7:0] PFX_AIND = 8'h91;
   localparam logic [7:0] OPC_HALT = 8'h8E;
   localparam logic [7:0] OPC_WFI = 8'h8F;
   localparam logic [15:0] PAGE0_TOP = 16'h00FF;
   localparam logic [7:0] ZERO8 = 8'h00;
   localparam logic [3:0] ROW_DIRECT_RMW = 4'h3;
   localparam logic [3:0] ROW_IDX1_RMW = 4'h6;
   localparam logic [3:0] ROW_IDX0_RMW = 4'h7;
   localparam logic [3:0] ROW_IMM = 4'hA;
   localparam logic [3:0] ROW_SHORT = 4'hB;
   localparam logic [3:0] ROW_LONG = 4'hC;
   localparam logic [3:0] ROW_LIDX = 4'hD;
   localparam logic [3:0] ROW_SIDX = 4'hE;
   localparam logic [3:0] ROW_NIDX = 4'hF;
   localparam logic [3:0] ROW_REL = 4'h2;
   localparam logic [3:0] ROW_BIT = 4'h1;
   localparam logic [3:0] ROW_BTJ = 4'h0;

   typedef enum logic [3:0] {
      CEAG_INHERENT, CEAG_IMMEDIATE, CEAG_DIRECT, CEAG_INDEXED,
      CEAG_INDIRECT, CEAG_IND_INDEXED, CEAG_RELATIVE, CEAG_BIT,
      CEAG_BIT_REL
   } ceag_mode_t;

   typedef enum logic [3:0] {
      S_OPC, S_OPA, S_OPB, S_PTRH, S_PTRL, S_DISP, S_DONE
   } ceag_state_t;

   typedef struct packed {
      logic valid;
      logic [7:0] data;
   } ceag_byte_t;

   typedef struct packed {
      logic req;
      logic [15:0] addr;
   } ceag_fetch_t;

   typedef struct packed {
      logic valid;
      ceag_mode_t mode;
      logic long_form;
      logic rmw;
      logic [15:0] ea;
      logic [2:0] len;
      logic [7:0] opcode;
   } ceag_result_t;
endpackage

// ### tb_cpu_effective_address_gen.sv
// Self-checking bench for the effective address unit with a memory model
`timescale 1ns/10ps
module tb_cpu_effective_address_gen;
   import ceag_pkg::*;
   logic mclk, srst, start, irq, busy, dev_reset, wait_state;
   logic [15:0] pc, a, e;
   logic [7:0] idx_x, idx_y, b0;
   logic [1:0] lat, k;
   ceag_byte_t rd;
   ceag_fetch_t fetch;
   ceag_result_t result;
   int error_cnt = 0;
   int compares = 0;
   int fetches = 0;
   integer seed = 32'hae84a60a;

   ceag_addr_gen ceag_addr_gen_i (.mclk(mclk), .srst(srst), .start(start),
      .pc(pc), .idx_x(idx_x), .idx_y(idx_y), .irq(irq), .rd(rd),
      .fetch(fetch), .result(result), .busy(busy), .dev_reset(dev_reset),
      .wait_state(wait_state));
   ceag_mem_model ceag_mem_model_i (.mclk(mclk), .lat(lat), .fetch(fetch),
      .rd(rd));

   initial begin
      mclk = 1'b0;
      forever #2 mclk = ~mclk;
   end
   always @(posedge mclk) if (fetch.req === 1'b1) fetches++;

   function automatic logic [15:0] rel_tgt(input logic [15:0] p,
      input logic [2:0] n, input logic [7:0] d);
      return p + 16'(n) + {{8{d[7]}}, d};
   endfunction
   function automatic logic [15:0] idx_sum(input logic [7:0] x,
      input logic [15:0] off);
      return {8'h00, x} + off;
   endfunction

   task automatic chk(input string nm, input logic [15:0] got,
      input logic [15:0] exp);
      compares++;
      if (got !== exp) begin
         error_cnt++;
         $display("ERROR %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic complete_run();
      $display("errors %0d compares %0d", error_cnt, compares);
      if (error_cnt == 0 && compares > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   // Loads the instruction bytes, then issues one start and waits for result
   task automatic exec(input logic [15:0] at, input logic [31:0] code,
      input int n);
      logic got;
      got = 1'b0;
      for (int i = 0; i < n; i++) begin
         ceag_mem_model_i.put(at + 16'(i), code[8*(n-1-i) +: 8]);
      end
      @(negedge mclk);
      lat = 2'($random(seed));
      pc = at;
      fetches = 0;
      start = 1'b1;
      @(negedge mclk);
      start = 1'b0;
      for (int j = 0; j < 200 && !got; j++) begin
         @(posedge mclk);
         #1 got = (result.valid === 1'b1);
      end
      chk("result.valid", 16'(got), 16'h0001);
      chk("busy", 16'(busy), 16'h0000);
   endtask

   initial begin
      #(4 * 20000);
      error_cnt++;
      complete_run();
   end

   initial begin
      srst = 1'b1; start = 1'b0; pc = 16'h0000; irq = 1'b0; lat = 2'h0;
      idx_x = 8'hFF; idx_y = 8'h3C;
      repeat (20) @(negedge mclk);
      srst = 1'b0;
      exec(16'h1000, 32'h80, 1);
      chk("len", 16'(result.len), 16'h0001);
      chk("fetches", 16'(fetches), 16'h0001);
      exec(16'h1010, 32'hA6C3, 2);
      chk("len", 16'(result.len), 16'h0002);
      chk("mode", 16'(result.mode), 16'(CEAG_IMMEDIATE));
      chk("opcode", 16'(result.opcode), 16'h00A6);
      exec(16'h1020, 32'hB6F7, 2);
      chk("ea", result.ea, 16'h00F7);
      chk("long", 16'(result.long_form), 16'h0000);
      exec(16'h1030, 32'hC68234, 3);
      chk("ea", result.ea, 16'h8234);
      chk("long", 16'(result.long_form), 16'h0001);
      exec(16'h1040, 32'hF6, 1);
      chk("ea", result.ea, 16'h00FF);
      exec(16'h1050, 32'h90F6, 2);
      chk("ea", result.ea, 16'h003C);
      chk("len", 16'(result.len), 16'h0002);
      exec(16'h1060, 32'hE6FF, 2);
      chk("ea", result.ea, 16'h01FE);
      exec(16'h1070, 32'hD67F80, 3);
      chk("ea", result.ea, idx_sum(8'hFF, 16'h7F80));
      exec(16'h1080, 32'h90D61234, 4);
      chk("ea", result.ea, idx_sum(8'h3C, 16'h1234));
      ceag_mem_model_i.put(16'h0040, 8'hD5);
      ceag_mem_model_i.put(16'h0050, 8'hAB);
      ceag_mem_model_i.put(16'h0051, 8'hCD);
      ceag_mem_model_i.put(16'h0060, 8'hF0);
      ceag_mem_model_i.put(16'h0070, 8'hFE);
      exec(16'h1090, 32'h92B640, 3);
      chk("ea", result.ea, 16'h00D5);
      exec(16'h10A0, 32'h92C650, 3);
      chk("ea", result.ea, 16'hABCD);
      exec(16'h10B0, 32'h92E660, 3);
      chk("ea", result.ea, 16'h01EF);
      exec(16'h10C0, 32'h91E660, 3);
      chk("ea", result.ea, 16'h012C);
      exec(16'h2000, 32'h2080, 2);
      chk("ea", result.ea, rel_tgt(16'h2000, 3'h2, 8'h80));
      exec(16'h2010, 32'h207F, 2);
      chk("ea", result.ea, rel_tgt(16'h2010, 3'h2, 8'h7F));
      exec(16'h2100, 32'h922070, 3);
      chk("ea", result.ea, rel_tgt(16'h2100, 3'h3, 8'hFE));
      exec(16'h2200, 32'h3A44, 2);
      chk("rmw", 16'(result.rmw), 16'h0001);
      chk("ea", result.ea, 16'h0044);
      // Random mix of short direct, short indexed and relative forms
      repeat (24) begin
         @(negedge mclk);
         k = 2'($unsigned($random(seed)) % 3);
         b0 = 8'($random(seed));
         a = 16'h4000 | 16'($random(seed));
         idx_x = 8'($random(seed));
         exec(a, {16'h0000, (k == 0) ? 8'hB6 : (k == 1) ? 8'hE6 : 8'h20, b0}, 2);
         e = (k == 0) ? {8'h00, b0} : (k == 1) ?
            idx_sum(idx_x, {8'h00, b0}) : rel_tgt(a, 3'h2, b0);
         chk("ea", result.ea, e);
      end
      exec(16'h3000, 32'h8F, 1);
      repeat (2) @(posedge mclk);
      #1 chk("wait_state", 16'(wait_state), 16'h0001);
      fetches = 0;
      @(negedge mclk);
      start = 1'b1;
      repeat (6) @(negedge mclk);
      start = 1'b0;
      chk("fetches", 16'(fetches), 16'h0000);
      irq = 1'b1;
      for (int j = 0; j < 10 && wait_state !== 1'b0; j++) @(posedge mclk);
      #1 chk("wait_state", 16'(wait_state), 16'h0000);
      @(negedge mclk);
      irq = 1'b0;
      exec(16'h3100, 32'h8E, 1);
      repeat (2) @(posedge mclk);
      #1 chk("dev_reset", 16'(dev_reset), 16'h0001);
      @(negedge mclk);
      srst = 1'b1;
      repeat (2) @(negedge mclk);
      srst = 1'b0;
      chk("dev_reset", 16'(dev_reset), 16'h0000);
      complete_run();
   end
endmodule
